// ### design/rsts_pkg.sv
// Package: test table, types and timing of the receiver self-test sequencer
package rsts_pkg;

  // ----------------------------------------------------------------
  // Test table
  // ----------------------------------------------------------------
  localparam int NTEST = 72;
  localparam int IW    = 7;
  localparam int NW    = 12;
  localparam int NSEC  = 6;
  localparam int SW    = 3;
  localparam int NOPT  = 3;
  localparam int F_PU  = 15;
  localparam int F_CM  = 14;
  localparam int F_UC  = 13;
  localparam int F_ST  = 12;

  // Entry: {power-up, continuous, unit confidence, select, number}
  localparam logic [15:0] TEST_TAB [NTEST] = '{
    16'h8001, 16'hb002, 16'hb003, 16'h4004, 16'h7005, 16'h7006, 16'h7007, 16'h7008,
    16'h1009, 16'h100a, 16'h1033, 16'h1034, 16'h1035, 16'h1036, 16'h4037, 16'hb065,
    16'hb066, 16'hb067, 16'hb068, 16'h1097, 16'h1098, 16'h70c9, 16'h70ca, 16'h70cb,
    16'h70cc, 16'h70cd, 16'h30ce, 16'h30cf, 16'h30d0, 16'h30d1, 16'h30d2, 16'h30d3,
    16'h30d4, 16'h30d5, 16'h30d6, 16'h30d7, 16'h30d8, 16'h30d9, 16'h30da, 16'h30db,
    16'h30dc, 16'h30dd, 16'h30de, 16'h30df, 16'h30e0, 16'h30e1, 16'h30e2, 16'h10e3,
    16'h10e4, 16'h10e5, 16'h10e6, 16'h10e7, 16'h10e8, 16'h30e9, 16'h10ea, 16'h70fb,
    16'h70fc, 16'h70fd, 16'h70fe, 16'h70ff, 16'h7100, 16'h3101, 16'h3102, 16'h3103,
    16'h3104, 16'h3105, 16'h3106, 16'h312d, 16'h312e, 16'h115f, 16'h1191, 16'h1192
  };

  // Sections start at these numbers; sections 3..5 are fitted options
  localparam logic [NW-1:0] SEC_BASE [NSEC] = '{
    12'h001, 12'h065, 12'h0c9, 12'h12d, 12'h15f, 12'h191
  };
  localparam logic [NW-1:0] CTRL_LAST_NUM = 12'h098;
  localparam logic [SW-1:0] CTRL_SECS     = 3'h2;
  localparam logic [SW-1:0] OPT_SEC0      = 3'h3;

  // ----------------------------------------------------------------
  // Timing and LED codes
  // ----------------------------------------------------------------
  localparam int FLASH_HALF_MS  = 250;
  localparam int CLK_KHZ        = 100_000;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_KHZ;
  localparam logic [1:0] LED_OFF   = 2'h0;
  localparam logic [1:0] LED_GREEN = 2'h1;
  localparam logic [1:0] LED_RED   = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_PU, ST_SETTINGS, ST_NORMAL, ST_MENU, ST_UC,
    ST_UC_HALT, ST_SEC, ST_TEST, ST_SCAN, ST_RUN
  } rsts_state_t;

  typedef enum logic [2:0] {
    DL_NORMAL, DL_OPTIONS, DL_UC, DL_HALT, DL_SECTION, DL_TEST, DL_RUN
  } rsts_level_t;

  typedef struct packed {
    logic softkey_one;
    logic softkey_two;
    logic softkey_three;
    logic softkey_four;
    logic recall_key;
    logic built_in_test_menu;
  } rsts_keys_t;

  typedef struct packed {
    logic          req;
    logic [NW-1:0] num;
  } rsts_test_req_t;

  typedef struct packed {
    logic done;
    logic pass;
  } rsts_test_rsp_t;

  typedef struct packed {
    rsts_level_t   level;
    logic [SW-1:0] sec;
    logic [NW-1:0] num;
    logic          labels;
    logic          res_valid;
    logic          res_pass;
  } rsts_disp_t;

  typedef struct packed {
    logic          valid;
    logic          tested;
    logic          failed;
    logic [NW-1:0] num;
  } rsts_detail_t;

  typedef struct packed {
    rsts_state_t    st;
    logic [IW-1:0]  idx;
    logic [IW-1:0]  cm_idx;
    logic [IW-1:0]  run_idx;
    logic [SW-1:0]  sec;
    logic           fg;
    rsts_test_req_t req;
    logic [NTEST-1:0] tested;
    logic [NTEST-1:0] failed;
    logic           fault;
    logic [NW-1:0]  fail_num;
    logic           apply;
    logic           rx_suspend;
    rsts_disp_t     disp;
    rsts_detail_t   detail;
  } rsts_core_t;

  // ----------------------------------------------------------------
  // Table helpers
  // ----------------------------------------------------------------
  function automatic logic [SW-1:0] sec_of(input logic [NW-1:0] num);
    sec_of = '0;
    for (int s = 1; s < NSEC; s++) begin
      if (num >= SEC_BASE[s]) sec_of = SW'(s);
    end
  endfunction

  function automatic logic sec_avail(input logic [SW-1:0] s, input logic ctrl,
                                     input logic [NOPT-1:0] opt);
    if (ctrl) sec_avail = (s < CTRL_SECS);
    else if (s < OPT_SEC0) sec_avail = 1'b1;
    else sec_avail = opt[2'(s - OPT_SEC0)];
  endfunction

  function automatic logic avail_num(input logic [NW-1:0] num, input logic ctrl,
                                     input logic [NOPT-1:0] opt);
    if (ctrl) avail_num = (num <= CTRL_LAST_NUM);
    else avail_num = sec_avail(sec_of(num), 1'b0, opt);
  endfunction

  function automatic logic hit(input logic [15:0] e, input int fb, input logic ctrl,
                               input logic [NOPT-1:0] opt);
    hit = e[fb] && avail_num(e[NW-1:0], ctrl, opt);
  endfunction

endpackage

// ### design/rsts_led_drv.sv
// Digital board status LEDs: processor heartbeat and PLL lock lamps
`timescale 1ns/1ps
module rsts_led_drv #(
  parameter int HALF_CYC = rsts_pkg::FLASH_HALF_CYC
) (
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic       fault_in,
  input  wire logic       pll1_lock_in,
  input  wire logic       pll2_lock_in,
  output logic [1:0]      proc_status_led_a_out,
  output logic [1:0]      proc_status_led_b_out,
  output logic            pll1_lock_led_out,
  output logic            pll2_lock_led_out
);
  import rsts_pkg::*;

  localparam int CW = $clog2(HALF_CYC + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          phase;
    logic [1:0]    led;
    logic          l1;
    logic          l2;
  } rsts_led_st_t;

  rsts_led_st_t q, d;

  // ----------------------------------------------------------------
  // Heartbeat
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    if (q.cnt == CW'(HALF_CYC - 1)) begin
      d.cnt   = '0;
      d.phase = ~q.phase;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
    // Colour follows fault at once so a new failure shows within one flash
    d.led = d.phase ? (fault_in ? LED_RED : LED_GREEN) : LED_OFF;
    // Lamps dark until the signal processors have set the dividers
    d.l1 = pll1_lock_in;
    d.l2 = pll2_lock_in;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) q <= '0;
    else q <= d;
  end

  assign proc_status_led_a_out = q.led;
  assign proc_status_led_b_out = q.led;
  assign pll1_lock_led_out     = q.l1;
  assign pll2_lock_led_out     = q.l2;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  led_colour_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (d.phase && fault_in) |=> proc_status_led_a_out == LED_RED && proc_status_led_b_out == LED_RED)
    else $error("status LEDs not red on fault");

  lock_lamp_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (!pll1_lock_in && pll2_lock_in) |=> !pll1_lock_led_out && pll2_lock_led_out)
    else $error("lock lamps do not follow PLL lock");

endmodule

// ### design/rsts_sequencer.sv
// Receiver self-test sequencer: power-up, monitoring, confidence and select tests
`timescale 1ns/1ps
// Functional notes
// - At power-up check saved settings; apply if intact, else light fault.
// - Run continuous monitoring tests whenever powered; any failure lights fault. Code starts them only after the power-up tests and settings check.
// - Power-up set is exactly tests 001, 002, 003 and 101 to 104.
// - Keep failure details after an automatic test fails for later reporting.
// - Unit confidence test suspends reception and injects the 5 MHz test source.
// - Unit confidence test halts at first failure and shows suspect section.
// - Select mode offers confidence tests plus extra ones, each choosable, repeatable.
// - Select mode opens on section list with labels; digital processor section first.
// - Keys one and two step; key three enters section showing first test.
// - Chosen test runs repeatedly with result shown until key four pressed.
// - Key four steps out: running test, test list, section list, options.
// - Recall key leaves the menu and returns to normal operation.
// - Processor LEDs flash green when normal, red after a detected failure.
// - Each PLL lock LED lights only while its PLL is locked.
// - PLL dividers come from signal processors; both lamps dark means stopped.
// - Offer only fitted-option tests; controller-only variant limits to 001-152.
// - Automatic tests need no operator; deeper modes come from menu request.
module rsts_sequencer #(
  parameter int FLASH_HALF_CYC = rsts_pkg::FLASH_HALF_CYC
) (
  input  wire logic                     core_clk_in,
  input  wire logic                     rst_in,
  input  wire rsts_pkg::rsts_keys_t     keys_in,
  input  wire logic                     controller_only_in,
  input  wire logic [rsts_pkg::NOPT-1:0] options_fitted_in,
  input  wire logic                     saved_settings_ok_in,
  input  wire rsts_pkg::rsts_test_rsp_t test_rsp_in,
  input  wire logic [rsts_pkg::IW-1:0]  detail_idx_in,
  input  wire logic                     pll1_lock_in,
  input  wire logic                     pll2_lock_in,
  output rsts_pkg::rsts_test_req_t      test_req_out,
  output logic                          fault_out,
  output logic                          apply_settings_out,
  output logic                          rx_suspend_out,
  output logic                          inject_5mhz_out,
  output rsts_pkg::rsts_disp_t          disp_out,
  output rsts_pkg::rsts_detail_t        detail_out,
  output logic [rsts_pkg::NW-1:0]       fault_num_out,
  output logic [1:0]                    proc_status_led_a_out,
  output logic [1:0]                    proc_status_led_b_out,
  output logic                          pll1_lock_led_out,
  output logic                          pll2_lock_led_out
);
  import rsts_pkg::*;

  rsts_core_t    q, d;
  logic [15:0]   cur;
  logic [15:0]   cme;
  logic          rsp;
  logic          rsp_fg;
  logic          rsp_cm;
  logic          last;
  logic          cm_state;
  logic          found;
  logic [SW-1:0] s_try;
  logic          ctl;
  logic [NOPT-1:0] opt;
  logic [IW-1:0] up_idx;
  logic          fg_go;
  logic          cm_want;
  logic [IW-1:0] cm_next;
  logic [IW-1:0] ridx;
  logic [NTEST-1:0] in_sec;
  int            j;

  assign ctl = controller_only_in;
  assign opt = options_fitted_in;

  // ----------------------------------------------------------------
  // Select-mode membership, one flag per table entry
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NTEST; g++) begin : g_sel
    assign in_sec[g] = hit(TEST_TAB[g], F_ST, ctl, opt)
                       && (sec_of(TEST_TAB[g][NW-1:0]) == q.sec);
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    found   = 1'b0;
    j       = 0;
    s_try   = q.sec;
    cur     = TEST_TAB[q.idx];
    cme     = TEST_TAB[q.cm_idx];
    rsp     = q.req.req && test_rsp_in.done;
    rsp_fg  = rsp && q.fg;
    rsp_cm  = rsp && !q.fg;
    last    = (q.idx == IW'(NTEST - 1));
    up_idx  = last ? '0 : q.idx + 1'b1;
    cm_state = (q.st != ST_PU) && (q.st != ST_SETTINGS);
    cm_want  = cm_state && hit(cme, F_CM, ctl, opt);
    // Foreground and monitoring alternate so neither starves
    fg_go    = !q.req.req && (!cm_want || !q.fg);
    cm_next  = (q.cm_idx == IW'(NTEST - 1)) ? '0 : q.cm_idx + 1'b1;
    ridx     = q.fg ? q.run_idx : q.cm_idx;
    if (rsp) begin
      d.req.req      = 1'b0;
      d.tested[ridx] = 1'b1;
      d.failed[ridx] = !test_rsp_in.pass;
      // Select-mode repeats report on screen only
      if (!test_rsp_in.pass && !(q.fg && q.st == ST_RUN)) begin
        d.fault    = 1'b1;
        d.fail_num = q.req.num;
      end
    end

    case (q.st)
      ST_PU: begin
        // Runs straight from reset, no key involved
        if (rsp_fg || (!q.req.req && !hit(cur, F_PU, ctl, opt))) begin
          if (last) d.st = ST_SETTINGS;
          else d.idx = up_idx;
        end else if (!q.req.req) begin
          d.req     = '{req: 1'b1, num: cur[NW-1:0]};
          d.run_idx = q.idx;
          d.fg      = 1'b1;
        end
      end
      ST_SETTINGS: begin
        if (saved_settings_ok_in) d.apply = 1'b1;
        else d.fault = 1'b1;
        d.st  = ST_NORMAL;
        d.idx = '0;
      end
      ST_NORMAL: begin
        if (keys_in.built_in_test_menu) d.st = ST_MENU;
      end
      ST_MENU: begin
        if (keys_in.softkey_one) begin
          d.st     = ST_UC;
          d.idx    = '0;
          d.tested = '0;
          d.failed = '0;
        end else if (keys_in.softkey_two) begin
          d.st  = ST_SEC;
          d.sec = '0;
        end
      end
      ST_UC: begin
        if (rsp_fg && !test_rsp_in.pass) begin
          d.st  = ST_UC_HALT;
          d.sec = sec_of(q.req.num);
        end else if (rsp_fg || (!q.req.req && !hit(cur, F_UC, ctl, opt))) begin
          if (last) d.st = ST_MENU;
          else d.idx = up_idx;
        end else if (fg_go) begin
          d.req     = '{req: 1'b1, num: cur[NW-1:0]};
          d.run_idx = q.idx;
          d.fg      = 1'b1;
        end
      end
      ST_UC_HALT: begin
        if (keys_in.softkey_four) d.st = ST_MENU;
      end
      ST_SEC: begin
        if (keys_in.softkey_one || keys_in.softkey_two) begin
          // Unfitted sections are skipped over in the stepping direction
          for (int k = 1; k < NSEC; k++) begin
            if (keys_in.softkey_one) s_try = (s_try == SW'(NSEC - 1)) ? '0 : s_try + 1'b1;
            else s_try = (s_try == '0) ? SW'(NSEC - 1) : s_try - 1'b1;
            if (!found && sec_avail(s_try, ctl, opt)) begin
              d.sec = s_try;
              found = 1'b1;
            end
          end
        end else if (keys_in.softkey_three) begin
          // Lowest-numbered test of the section is shown first
          for (int i = NTEST - 1; i >= 0; i--) begin
            if (in_sec[i]) begin
              d.idx = IW'(i);
              found = 1'b1;
            end
          end
          if (found) d.st = ST_TEST;
        end else if (keys_in.softkey_four) begin
          d.st = ST_MENU;
        end
      end
      ST_TEST: begin
        if (keys_in.softkey_one || keys_in.softkey_two) begin
          // Nearest member in the stepping direction wins
          for (int k = NTEST - 1; k > 0; k--) begin
            if (keys_in.softkey_one) j = (int'(q.idx) + k) % NTEST;
            else j = (int'(q.idx) + NTEST - k) % NTEST;
            if (in_sec[j]) d.idx = IW'(j);
          end
        end else if (keys_in.softkey_three) begin
          d.st             = ST_RUN;
          d.run_idx        = q.idx;
          d.disp.res_valid = 1'b0;
        end else if (keys_in.softkey_four) begin
          d.st = ST_SEC;
        end
      end
      ST_RUN: begin
        if (rsp_fg) begin
          d.disp.res_valid = 1'b1;
          d.disp.res_pass  = test_rsp_in.pass;
        end
        if (keys_in.softkey_four) begin
          d.st = ST_TEST;
        end else if (fg_go) begin
          d.req = '{req: 1'b1, num: TEST_TAB[q.run_idx][NW-1:0]};
          d.fg  = 1'b1;
        end
      end
      default: d.st = ST_NORMAL;
    endcase

    // Monitoring holds on an entry until it gets its turn
    if (rsp_cm || (!cm_want && !(q.req.req && !q.fg))) d.cm_idx = cm_next;
    if (!q.req.req && !d.req.req && cm_want) begin
      d.req = '{req: 1'b1, num: cme[NW-1:0]};
      d.fg  = 1'b0;
    end
    if (keys_in.recall_key && cm_state) d.st = ST_NORMAL;

    d.rx_suspend = (d.st == ST_UC) || (d.st == ST_UC_HALT);
    case (d.st)
      ST_MENU:    d.disp.level = DL_OPTIONS;
      ST_UC:      d.disp.level = DL_UC;
      ST_UC_HALT: d.disp.level = DL_HALT;
      ST_SEC:     d.disp.level = DL_SECTION;
      ST_TEST:    d.disp.level = DL_TEST;
      ST_RUN:     d.disp.level = DL_RUN;
      default:    d.disp.level = DL_NORMAL;
    endcase
    d.disp.labels = (d.st == ST_SEC) || (d.st == ST_TEST) || (d.st == ST_RUN);
    d.disp.sec    = d.sec;
    d.disp.num    = TEST_TAB[d.idx][NW-1:0];
    // Fault detail is looked up by table position
    d.detail.valid  = q.fault;
    d.detail.tested = q.tested[detail_idx_in];
    d.detail.failed = q.failed[detail_idx_in];
    d.detail.num    = TEST_TAB[detail_idx_in][NW-1:0];
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) q <= '0;
    else q <= d;
  end

  assign test_req_out       = q.req;
  assign fault_out          = q.fault;
  assign apply_settings_out = q.apply;
  assign rx_suspend_out     = q.rx_suspend;
  assign inject_5mhz_out    = q.rx_suspend;
  assign disp_out           = q.disp;
  assign detail_out         = q.detail;
  assign fault_num_out      = q.fail_num;

  // ----------------------------------------------------------------
  // Status LEDs
  // ----------------------------------------------------------------
  rsts_led_drv #(.HALF_CYC(FLASH_HALF_CYC)) rsts_led_drv_i (
    .core_clk_in          (core_clk_in),
    .rst_in               (rst_in),
    .fault_in             (q.fault),
    .pll1_lock_in         (pll1_lock_in),
    .pll2_lock_in         (pll2_lock_in),
    .proc_status_led_a_out(proc_status_led_a_out),
    .proc_status_led_b_out(proc_status_led_b_out),
    .pll1_lock_led_out    (pll1_lock_led_out),
    .pll2_lock_led_out    (pll2_lock_led_out)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  monitor_fault_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (rsp_cm && !test_rsp_in.pass) |=> fault_out)
    else $error("monitoring failure did not raise fault");

  confidence_halt_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (q.st == ST_UC && rsp_fg && !test_rsp_in.pass && !keys_in.recall_key)
    |=> q.st == ST_UC_HALT)
    else $error("confidence test did not halt on failure");

  recall_exit_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (keys_in.recall_key && cm_state) |=> q.st == ST_NORMAL)
    else $error("recall key did not leave the menu");

  uc_suspend_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    q.st == ST_UC |-> rx_suspend_out && inject_5mhz_out)
    else $error("reception not suspended in confidence test");

  ctrl_limit_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (test_req_out.req && controller_only_in) |-> test_req_out.num <= CTRL_LAST_NUM)
    else $error("controller variant requested an unfitted test");

  halt_seen_c: cover property (@(posedge core_clk_in) q.st == ST_UC_HALT);
  run_result_c: cover property (@(posedge core_clk_in) q.st == ST_RUN && rsp_fg);
  monitor_fail_c: cover property (@(posedge core_clk_in) rsp_cm && !test_rsp_in.pass);

endmodule

// ### verif/rsts_test_model.sv
// Far-side test executor model: answers each test request after a delay
`timescale 1ns/1ps
module rsts_test_model (
  input  wire logic                     core_clk_in,
  input  wire logic                     rst_in,
  input  wire rsts_pkg::rsts_test_req_t test_req_in,
  input  wire logic [rsts_pkg::NW-1:0]  fail_num_in,
  input  wire logic [3:0]               delay_in,
  output rsts_pkg::rsts_test_rsp_t      test_rsp_out,
  output logic [rsts_pkg::NW-1:0]       last_num_out,
  output logic [rsts_pkg::NW-1:0]       max_num_out,
  output logic [rsts_pkg::NW-1:0]       log_out [8],
  output int                            req_cnt_out
);
  import rsts_pkg::*;
  logic       busy;
  logic [3:0] cnt;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy         <= 1'b0;
      cnt          <= '0;
      test_rsp_out <= '0;
      last_num_out <= '0;
      max_num_out  <= '0;
      req_cnt_out  <= 0;
    end else begin
      test_rsp_out.done <= 1'b0;
      // Pass line wanders while no answer is due, so stale reads show up
      test_rsp_out.pass <= ~test_rsp_out.pass;
      if (!busy && test_req_in.req && !test_rsp_out.done) begin
        busy         <= 1'b1;
        cnt          <= delay_in;
        last_num_out <= test_req_in.num;
        if (req_cnt_out < 8) log_out[req_cnt_out[2:0]] <= test_req_in.num;
        if (test_req_in.num > max_num_out) max_num_out <= test_req_in.num;
        req_cnt_out  <= req_cnt_out + 1;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy              <= 1'b0;
        test_rsp_out.done <= 1'b1;
        test_rsp_out.pass <= (last_num_out != fail_num_in);
      end
    end
  end
endmodule

// ### verif/receiver_self_test_sequencer_test.sv
// Self-checking bench for the receiver self-test sequencer
`timescale 1ns/1ps
module receiver_self_test_sequencer_test;
  import rsts_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  // Short flash period keeps the LED scenarios brief
  localparam int         HALF = 8;
  localparam rsts_keys_t K1   = 6'h20;
  localparam rsts_keys_t K2   = 6'h10;
  localparam rsts_keys_t K3   = 6'h08;
  localparam rsts_keys_t K4   = 6'h04;
  localparam rsts_keys_t KR   = 6'h02;
  localparam rsts_keys_t KM   = 6'h01;
  localparam logic [NW-1:0] PU_NUM [7] = '{12'h001, 12'h002, 12'h003, 12'h065, 12'h066,
                                           12'h067, 12'h068};
  logic            clk  = 1'b0;
  logic            rst  = 1'b1;
  rsts_keys_t      keys = '0;
  logic            ctrl = 1'b0;
  logic [NOPT-1:0] opt  = 3'h7;
  logic            ok   = 1'b1;
  logic [IW-1:0]   didx = '0;
  logic            pll1 = 1'b0;
  logic            pll2 = 1'b0;
  logic [NW-1:0]   fnum = 12'hfff;
  logic [3:0]      dly  = 4'h3;
  rsts_test_req_t  req;
  rsts_test_rsp_t  rsp;
  rsts_disp_t      disp;
  rsts_detail_t    det;
  logic            fault, apply, susp, inj, l1, l2;
  logic [1:0]      la, lb;
  logic [NW-1:0]   fno, lastn, maxn;
  logic [NW-1:0]   log_q [8];
  int              reqs;
  int              error_cnt = 0;
  int              checks = 0;

  always #5 clk = ~clk;

  rsts_sequencer #(.FLASH_HALF_CYC(HALF)) rsts_sequencer_i (
    .core_clk_in          (clk),
    .rst_in               (rst),
    .keys_in              (keys),
    .controller_only_in   (ctrl),
    .options_fitted_in    (opt),
    .saved_settings_ok_in (ok),
    .test_rsp_in          (rsp),
    .detail_idx_in        (didx),
    .pll1_lock_in         (pll1),
    .pll2_lock_in         (pll2),
    .test_req_out         (req),
    .fault_out            (fault),
    .apply_settings_out   (apply),
    .rx_suspend_out       (susp),
    .inject_5mhz_out      (inj),
    .disp_out             (disp),
    .detail_out           (det),
    .fault_num_out        (fno),
    .proc_status_led_a_out(la),
    .proc_status_led_b_out(lb),
    .pll1_lock_led_out    (l1),
    .pll2_lock_led_out    (l2)
  );

  rsts_test_model rsts_test_model_i (
    .core_clk_in (clk),
    .rst_in      (rst),
    .test_req_in (req),
    .fail_num_in (fnum),
    .delay_in    (dly),
    .test_rsp_out(rsp),
    .last_num_out(lastn),
    .max_num_out (maxn),
    .log_out     (log_q),
    .req_cnt_out (reqs)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic do_reset(input logic ok_v, input logic ctrl_v);
    @(posedge clk);
    rst  <= 1'b1;
    ok   <= ok_v;
    ctrl <= ctrl_v;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
  endtask

  task automatic press(input rsts_keys_t k);
    @(posedge clk);
    keys <= k;
    @(posedge clk);
    keys <= '0;
    cyc(4);
  endtask

  task automatic led_seen(output int g, output int r);
    g = 0;
    r = 0;
    for (int n = 0; n < 4 * HALF; n++) begin
      cyc(1);
      g += (la === LED_GREEN && lb === LED_GREEN);
      r += (la === LED_RED && lb === LED_RED);
    end
  endtask

  task automatic pll_case(input logic a, input logic b);
    @(posedge clk);
    pll1 <= a;
    pll2 <= b;
    cyc(3);
    check("pll_led", {l1, l2}, {a, b});
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_powerup();
    int g;
    int r;
    for (int n = 0; n < 3000 && apply !== 1'b1; n++) cyc(1);
    check("apply", apply, 1'b1);
    check("fault", fault, 1'b0);
    for (int i = 0; i < 7; i++) check("pu_num", log_q[i], PU_NUM[i]);
    led_seen(g, r);
    check("green", g > 0, 1'b1);
    check("red", r, 0);
    pll_case(1'b1, 1'b1);
    pll_case(1'b0, 1'b1);
    pll_case(1'b1, 1'b0);
    pll_case(1'b0, 1'b0);
  endtask

  task automatic t_corrupt();
    int g;
    int r;
    do_reset(1'b0, 1'b0);
    for (int n = 0; n < 3000 && fault !== 1'b1; n++) cyc(1);
    check("fault", fault, 1'b1);
    check("apply", apply, 1'b0);
    led_seen(g, r);
    check("red", r > 0, 1'b1);
    check("green", g, 0);
  endtask

  task automatic t_monitor();
    fnum <= 12'h004;
    didx <= 7'h03;
    dly  <= 4'h9;
    do_reset(1'b1, 1'b0);
    for (int n = 0; n < 5000 && fault !== 1'b1; n++) cyc(1);
    check("fault", fault, 1'b1);
    check("apply", apply, 1'b1);
    check("fault_num", fno, 12'h004);
    cyc(2);
    check("detail", {det.valid, det.tested, det.failed}, 3'h7);
    check("detail_num", det.num, 12'h004);
  endtask

  task automatic t_select();
    int r;
    fnum <= 12'hfff;
    dly  <= 4'h1;
    do_reset(1'b1, 1'b0);
    for (int n = 0; n < 3000 && apply !== 1'b1; n++) cyc(1);
    press(KM);
    check("level", disp.level, DL_OPTIONS);
    press(K2);
    check("level", disp.level, DL_SECTION);
    check("sec", disp.sec, 3'h0);
    check("labels", disp.labels, 1'b1);
    press(K1);
    check("sec", disp.sec, 3'h1);
    press(K3);
    check("level", disp.level, DL_TEST);
    check("num", disp.num, 12'h065);
    r = reqs;
    press(K3);
    check("level", disp.level, DL_RUN);
    cyc(200);
    check("repeats", reqs - r > 2, 1'b1);
    check("result", disp.res_valid, 1'b1);
    press(K4);
    check("level", disp.level, DL_TEST);
    press(K4);
    check("level", disp.level, DL_SECTION);
    press(K4);
    check("level", disp.level, DL_OPTIONS);
    press(KR);
    check("level", disp.level, DL_NORMAL);
  endtask

  task automatic t_confidence();
    fnum <= 12'h0cf;
    press(KM);
    press(K1);
    check("suspend", susp, 1'b1);
    check("inject", inj, 1'b1);
    for (int n = 0; n < 3000 && disp.level !== DL_HALT; n++) cyc(1);
    check("level", disp.level, DL_HALT);
    check("sec", disp.sec, 3'h2);
    press(KR);
    check("level", disp.level, DL_NORMAL);
    check("suspend", susp, 1'b0);
  endtask

  task automatic t_ctrl();
    fnum <= 12'hfff;
    opt  <= '0;
    do_reset(1'b1, 1'b1);
    cyc(3000);
    check("max_num", maxn <= 12'h098, 1'b1);
    check("auto_run", reqs > 7, 1'b1);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    t_powerup();
    t_corrupt();
    t_monitor();
    t_select();
    t_confidence();
    t_ctrl();
    finish_test();
  end

  // Whole run needs well under 40000 cycles
  initial begin
    #400us;
    error_cnt++;
    finish_test();
  end
endmodule
